// ===== core/pdsc_pkg.sv
// Shared constants and types for the synthesizer serial control block
package pdsc_pkg;
  localparam int WORD_W = 24;
  localparam int R_W    = 14;
  localparam int B_W    = 13;
  localparam int A_W    = 5;

  typedef enum logic [1:0] {
    LAT_CTRL = 2'b00,
    LAT_REF  = 2'b01,
    LAT_FB   = 2'b10,
    LAT_TEST = 2'b11
  } pdsc_latch_type;

  // Control latch fields
  localparam int CTL_PRESC_LSB = 22;
  localparam int CTL_PD1_BIT   = 20;
  localparam int CTL_MUTE_BIT  = 11;
  localparam int CTL_MON_LSB   = 5;
  localparam int CTL_CRST_BIT  = 4;
  // Reference latch fields
  localparam int REF_R_LSB     = 2;
  localparam int REF_ABP_LSB   = 16;
  localparam int REF_LDP_BIT   = 18;
  localparam int REF_BSC_LSB   = 20;
  // Feedback latch fields
  localparam int FB_A_LSB      = 2;
  localparam int FB_B_LSB      = 8;
  localparam int FB_HALF_BIT   = 22;

  localparam logic [23:0] LATCH_RST = 24'h000000;

  // Prescaler base moduli
  localparam logic [5:0] PRESC_8  = 6'h08;
  localparam logic [5:0] PRESC_16 = 6'h10;
  localparam logic [5:0] PRESC_32 = 6'h20;

  // Monitor pin sources
  localparam logic [2:0] MON_OFF    = 3'h0;
  localparam logic [2:0] MON_DLOCK  = 3'h1;
  localparam logic [2:0] MON_FBDIV  = 3'h2;
  localparam logic [2:0] MON_HIGH   = 3'h3;
  localparam logic [2:0] MON_REFDIV = 3'h4;
  localparam logic [2:0] MON_ALOCK  = 3'h5;

  // Lock detect timing, band select length and start band
  localparam int CLK_PERIOD_NS = 8;
  localparam int LOCK_SET_NS   = 15;
  localparam int UNLOCK_NS     = 25;
  localparam int LOCK_SET_CYC  = (LOCK_SET_NS / CLK_PERIOD_NS < 1) ? 1
                                 : LOCK_SET_NS / CLK_PERIOD_NS;
  localparam int UNLOCK_CYC    = (UNLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] LOCK_RUN_LO = 3'h3;
  localparam logic [2:0] LOCK_RUN_HI = 3'h5;
  localparam logic [2:0] BAND_CYCLES = 3'h5;
  localparam logic [2:0] BAND_START  = 3'h4;

  // Host registers on APB
  localparam logic [7:0] HREG_WORD   = 8'h00;
  localparam logic [7:0] HREG_CTRL   = 8'h04;
  localparam logic [7:0] HREG_STATUS = 8'h08;
  localparam logic [7:0] HREG_HALF   = 8'h0c;
  localparam logic [7:0] HALF_RST    = 8'h04;
  localparam logic       CE_RST      = 1'b0;

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_SHIFT = 2'b01,
    HS_LOAD  = 2'b10
  } pdsc_hstate_type;
endpackage

// ===== core/pdsc_if.sv
// Three-wire programming port, chip enable and monitor pin between host and device
`timescale 1ns/1ns
interface pdsc_if;
  logic serialClk;
  logic serialData;
  logic latchLoadStrobe;
  logic chipEnable;
  logic monOut;
  logic monOe;
  logic monitorPin;

  // Monitor pin has an external pull-up for the open-drain mode
  assign monitorPin = monOe ? monOut : 1'b1;

  modport dev  (input serialClk, serialData, latchLoadStrobe, chipEnable,
                output monOut, monOe);
  modport host (output serialClk, serialData, latchLoadStrobe, chipEnable,
                input monitorPin);
endinterface

// ===== core/pdsc_device.sv
// Synthesizer digital section: serial latches, dividers, lock detect, band select
// What this block does
// - Shift serial data in on clock rise
// - Host sends MSB first, select bits last
// - Load strobe rise copies word to latch
// - Select 00 ctrl, 01 ref, 10 fb, 11 test
// - Host never writes the test latch
// - Prescaler divides 8/9, 16/17 or 32/33
// - N equals B times P plus A
// - B 13-bit 3..8191, A 5-bit 0..31
// - Host keeps prescaler output within 300 MHz
// - Reference divider 14-bit, ratio 1..16383
// - Two bits set antibacklash pulse width
// - Three bits pick monitor pin source
// - Precision 0: three good cycles lock
// - Precision 1: five good cycles lock
// - Lock holds until error exceeds 25 ns
// - Analog lock high with low pulses
// - Band select at power-up and fb write
// - Host writes ref, control, then feedback
// - Band select five cycles, tune to reference
// - Band clock divides by 1, 2, 4, 8
// - Half-rate bit selects divide-by-two output
// - Mute output until digital lock
// - Chip enable low holds dividers and lock, turns off pump and output
`timescale 1ns/1ns
module pdsc_device #(
  parameter int RW = pdsc_pkg::R_W,
  parameter int BW = pdsc_pkg::B_W,
  parameter int AW = pdsc_pkg::A_W
) (
  input  wire logic       clk_sys,      // System clock, 125 MHz
  input  wire logic       sys_rst,      // Asynchronous reset, active high
  pdsc_if.dev             link,         // Serial port and monitor pin
  input  wire logic       refIn,        // Reference oscillator pin
  input  wire logic       vcoIn,        // Oscillator feedback pin
  output logic            pfdRefPulse,  // Divided reference, one cycle
  output logic            fbPulse,      // Divided feedback, one cycle
  output logic            lockDetect,   // Digital lock, active high
  output logic            tuneToRef,    // Band select running
  output logic [2:0]      bandCode,     // Chosen oscillator band
  output logic [1:0]      pulseWidth,   // Antibacklash delay select
  output logic            halfRate,     // Divide-by-two output
  output logic            rfOutEnable,  // Output stage powered
  output logic            pumpEnable    // Charge pump active
);
  localparam int NS = 6;
  logic [NS-1:0] sync1_ff, sync2_ff, prev_ff;
  logic [NS-1:0] rawIn;
  assign rawIn = {link.chipEnable, vcoIn, refIn, link.latchLoadStrobe,
                  link.serialData, link.serialClk};

  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
          prev_ff[gi]  <= 1'b0;
        end else begin
          sync1_ff[gi] <= rawIn[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          prev_ff[gi]  <= sync2_ff[gi];
        end
      end
    end
  endgenerate

  wire sclkRise = sync2_ff[0] & ~prev_ff[0];
  wire dataBit  = sync2_ff[1];
  wire loadRise = sync2_ff[2] & ~prev_ff[2];
  wire refRise  = sync2_ff[3] & ~prev_ff[3];
  wire vcoRise  = sync2_ff[4] & ~prev_ff[4];
  wire ceLevel  = sync2_ff[5];

  // Serial shift register and latches
  logic [23:0] shift_ff, ctrl_ff, ref_ff, fb_ff, test_ff;
  pdsc_pkg::pdsc_latch_type latchSel;
  assign latchSel = pdsc_pkg::pdsc_latch_type'(shift_ff[1:0]);
  wire ldCtrl = loadRise && latchSel == pdsc_pkg::LAT_CTRL;
  wire ldRef  = loadRise && latchSel == pdsc_pkg::LAT_REF;
  wire ldFb   = loadRise && latchSel == pdsc_pkg::LAT_FB;
  wire ldTest = loadRise && latchSel == pdsc_pkg::LAT_TEST;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      shift_ff <= pdsc_pkg::LATCH_RST;
      ctrl_ff  <= pdsc_pkg::LATCH_RST;
      ref_ff   <= pdsc_pkg::LATCH_RST;
      fb_ff    <= pdsc_pkg::LATCH_RST;
      test_ff  <= pdsc_pkg::LATCH_RST;
    end else begin
      if (sclkRise) shift_ff <= {shift_ff[22:0], dataBit};
      if (ldCtrl) ctrl_ff <= shift_ff;
      if (ldRef)  ref_ff  <= shift_ff;
      if (ldFb)   fb_ff   <= shift_ff;
      if (ldTest) test_ff <= shift_ff;
    end
  end

  // Latch fields
  wire [1:0]    prescSel = ctrl_ff[pdsc_pkg::CTL_PRESC_LSB +: 2];
  wire          pd1      = ctrl_ff[pdsc_pkg::CTL_PD1_BIT];
  wire          muteBit  = ctrl_ff[pdsc_pkg::CTL_MUTE_BIT];
  wire [2:0]    monSel   = ctrl_ff[pdsc_pkg::CTL_MON_LSB +: 3];
  wire          cntRst   = ctrl_ff[pdsc_pkg::CTL_CRST_BIT];
  wire [RW-1:0] rRatio   = ref_ff[pdsc_pkg::REF_R_LSB +: RW];
  wire          lock_precision_select      = ref_ff[pdsc_pkg::REF_LDP_BIT];
  wire [1:0]    bscSel   = ref_ff[pdsc_pkg::REF_BSC_LSB +: 2];
  wire [AW-1:0] aRatio   = fb_ff[pdsc_pkg::FB_A_LSB +: AW];
  wire [BW-1:0] bRatio   = fb_ff[pdsc_pkg::FB_B_LSB +: BW];

  wire powered = ceLevel & ~pd1;
  wire hold    = ~powered | cntRst;

  // Dual-modulus prescaler; one counter runs to P+1 while A is nonzero, else to P
  logic [5:0]    pCnt_ff;
  logic [AW-1:0] aCnt_ff;
  logic [BW-1:0] bCnt_ff;
  wire [5:0] pBase = (prescSel == 2'b00) ? pdsc_pkg::PRESC_8 :
                     (prescSel == 2'b01) ? pdsc_pkg::PRESC_16 : pdsc_pkg::PRESC_32;
  wire [5:0] pMod  = (aCnt_ff != '0) ? 6'(pBase + 6'h01) : pBase;
  wire       pOut  = vcoRise && pCnt_ff == 6'(pMod - 6'h01);
  wire       bEnd  = pOut && bCnt_ff <= BW'(1);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pCnt_ff <= 6'h00;
      aCnt_ff <= '0;
      bCnt_ff <= '0;
      fbPulse <= 1'b0;
    end else if (hold || ldFb) begin
      pCnt_ff <= 6'h00;
      aCnt_ff <= aRatio;
      bCnt_ff <= bRatio;
      fbPulse <= 1'b0;
    end else begin
      fbPulse <= bEnd;
      if (pOut) pCnt_ff <= 6'h00;
      else if (vcoRise) pCnt_ff <= 6'(pCnt_ff + 6'h01);
      if (bEnd) begin
        aCnt_ff <= aRatio;
        bCnt_ff <= bRatio;
      end else if (pOut) begin
        if (aCnt_ff != '0) aCnt_ff <= AW'(aCnt_ff - AW'(1));
        bCnt_ff <= BW'(bCnt_ff - BW'(1));
      end
    end
  end

  // Reference divider; a ratio of zero acts as one
  logic [RW-1:0] rCnt_ff;
  wire rEnd = refRise && (rCnt_ff >= RW'(rRatio - RW'(1)) || rRatio == '0);
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rCnt_ff     <= '0;
      pfdRefPulse <= 1'b0;
    end else if (hold) begin
      rCnt_ff     <= '0;
      pfdRefPulse <= 1'b0;
    end else begin
      pfdRefPulse <= rEnd;
      if (rEnd) rCnt_ff <= '0;
      else if (refRise) rCnt_ff <= RW'(rCnt_ff + RW'(1));
    end
  end

  // Phase error window and digital lock detect
  logic       winOpen_ff, winByRef_ff, lock_ff;
  logic [7:0] errCnt_ff;
  logic [2:0] run_ff;
  wire anyEdge = pfdRefPulse | fbPulse;
  wire closing = winOpen_ff && anyEdge;
  wire sameBoth = ~winOpen_ff && pfdRefPulse && fbPulse;
  wire wrongEdge = closing && (winByRef_ff ? ~fbPulse : ~pfdRefPulse);
  wire goodCyc = sameBoth || (closing && ~wrongEdge && errCnt_ff < 8'(pdsc_pkg::LOCK_SET_CYC));
  wire badCyc  = wrongEdge || (closing && errCnt_ff > 8'(pdsc_pkg::UNLOCK_CYC));
  wire [2:0] runNeed = lock_precision_select ? pdsc_pkg::LOCK_RUN_HI : pdsc_pkg::LOCK_RUN_LO;
  wire [2:0] nxt_run = goodCyc ? ((run_ff < runNeed) ? 3'(run_ff + 3'h1) : run_ff)
                       : (closing ? 3'h0 : run_ff);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      winOpen_ff  <= 1'b0;
      winByRef_ff <= 1'b0;
      errCnt_ff   <= 8'h00;
      run_ff      <= 3'h0;
      lock_ff     <= 1'b0;
    end else if (hold) begin
      winOpen_ff <= 1'b0;
      run_ff     <= 3'h0;
      lock_ff    <= 1'b0;
    end else begin
      run_ff <= nxt_run;
      if (nxt_run == runNeed) lock_ff <= 1'b1;
      else if (badCyc) lock_ff <= 1'b0;
      if (~winOpen_ff && anyEdge && ~sameBoth) begin
        winOpen_ff  <= 1'b1;
        winByRef_ff <= pfdRefPulse;
        errCnt_ff   <= 8'h00;
      end else if (closing) begin
        winOpen_ff <= 1'b0;
      end else if (winOpen_ff && errCnt_ff != 8'hff) begin
        errCnt_ff <= 8'(errCnt_ff + 8'h01);
      end
    end
  end
  assign lockDetect = lock_ff;

  // Band select: successive approximation on edge surplus per band clock
  logic [2:0] bscCnt_ff, step_ff, band_ff, trial_ff;
  logic       busy_ff, pending_ff;
  logic signed [7:0] diff_ff;
  wire [2:0] bscTop   = 3'((4'h1 << bscSel) - 4'h1);
  wire       bandTick = pfdRefPulse && bscCnt_ff == bscTop;
  wire [7:0] nxt_diff = 8'(diff_ff + {7'h00, fbPulse} - {7'h00, pfdRefPulse});

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bscCnt_ff  <= 3'h0;
      step_ff    <= 3'h0;
      band_ff    <= pdsc_pkg::BAND_START;
      trial_ff   <= pdsc_pkg::BAND_START;
      busy_ff    <= 1'b0;
      pending_ff <= 1'b1;
      diff_ff    <= 8'sh00;
    end else begin
      if (ldFb) pending_ff <= 1'b1;
      if (pfdRefPulse) bscCnt_ff <= bandTick ? 3'h0 : 3'(bscCnt_ff + 3'h1);
      diff_ff <= bandTick ? 8'sh00 : $signed(nxt_diff);
      if (pending_ff && powered && ~ldFb) begin
        pending_ff <= 1'b0;
        busy_ff    <= 1'b1;
        step_ff    <= 3'h0;
        band_ff    <= pdsc_pkg::BAND_START;
        trial_ff   <= pdsc_pkg::BAND_START;
      end else if (busy_ff && bandTick) begin
        step_ff <= 3'(step_ff + 3'h1);
        if (step_ff < 3'h3) begin
          band_ff  <= (($signed(nxt_diff) > 0) ? (band_ff & ~trial_ff) : band_ff)
                      | (trial_ff >> 1);
          trial_ff <= trial_ff >> 1;
        end
        if (step_ff == 3'(pdsc_pkg::BAND_CYCLES - 3'h1)) busy_ff <= 1'b0;
      end
    end
  end
  assign tuneToRef = busy_ff;
  assign bandCode  = band_ff;

  // Monitor pin, output controls
  logic fbDiv_ff, refDiv_ff, monOut_ff, monOe_ff, rfEn_ff, half_ff, pump_ff;
  logic [1:0] abp_ff;
  logic nxt_monOut, nxt_monOe;
  always_comb begin
    nxt_monOut = 1'b0;
    nxt_monOe  = 1'b1;
    case (monSel)
      pdsc_pkg::MON_OFF:    nxt_monOe = 1'b0;
      pdsc_pkg::MON_DLOCK:  nxt_monOut = lock_ff;
      pdsc_pkg::MON_FBDIV:  nxt_monOut = fbDiv_ff;
      pdsc_pkg::MON_HIGH:   nxt_monOut = 1'b1;
      pdsc_pkg::MON_REFDIV: nxt_monOut = refDiv_ff;
      pdsc_pkg::MON_ALOCK:  nxt_monOe = winOpen_ff | ~lock_ff;
      default:              nxt_monOut = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fbDiv_ff  <= 1'b0;
      refDiv_ff <= 1'b0;
      monOut_ff <= 1'b0;
      monOe_ff  <= 1'b0;
      rfEn_ff   <= 1'b0;
      half_ff   <= 1'b0;
      pump_ff   <= 1'b0;
      abp_ff    <= 2'h0;
    end else begin
      if (fbPulse) fbDiv_ff <= ~fbDiv_ff;
      if (pfdRefPulse) refDiv_ff <= ~refDiv_ff;
      monOut_ff <= nxt_monOut;
      monOe_ff  <= nxt_monOe;
      rfEn_ff   <= powered && (~muteBit || lock_ff);
      half_ff   <= fb_ff[pdsc_pkg::FB_HALF_BIT];
      pump_ff   <= powered && ~busy_ff;
      abp_ff    <= ref_ff[pdsc_pkg::REF_ABP_LSB +: 2];
    end
  end
  assign link.monOut  = monOut_ff;
  assign link.monOe   = monOe_ff;
  assign rfOutEnable  = rfEn_ff;
  assign halfRate     = half_ff;
  assign pumpEnable   = pump_ff;
  assign pulseWidth   = abp_ff;
endmodule

// ===== core/pdsc_host.sv
// Host end: APB registers drive the three-wire programming port
`timescale 1ns/1ns
module pdsc_host (
  input  wire logic        clk_sys,  // System clock, 125 MHz
  input  wire logic        sys_rst,  // Asynchronous reset, active high
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB access phase
  input  wire logic        pwrite,   // APB write
  input  wire logic [7:0]  paddr,    // APB byte address
  input  wire logic [31:0] pwdata,   // APB write data
  output logic [31:0]      prdata,   // APB read data
  output logic             pready,   // APB ready
  output logic             pslverr,  // APB error
  pdsc_if.host             link      // Serial port and monitor pin
);
  logic [23:0] word_ff;
  logic [7:0]  half_ff, divCnt_ff;
  logic        ce_ff, sclk_ff, le_ff, phase_ff, err_ff;
  logic [4:0]  bitCnt_ff;
  logic [1:0]  monSync_ff;
  logic [31:0] rdata_ff;
  pdsc_pkg::pdsc_hstate_type state_ff;

  wire busy     = state_ff != pdsc_pkg::HS_IDLE;
  wire selWord  = paddr == pdsc_pkg::HREG_WORD;
  wire selCtrl  = paddr == pdsc_pkg::HREG_CTRL;
  wire selStat  = paddr == pdsc_pkg::HREG_STATUS;
  wire selHalf  = paddr == pdsc_pkg::HREG_HALF;
  wire mapped   = selWord | selCtrl | selStat | selHalf;
  wire testWord = pwdata[1:0] == pdsc_pkg::LAT_TEST;
  // A word write waits while a previous word is still shifting out
  assign pready  = ~(selWord && pwrite && busy);
  wire   access  = psel && penable && pready;
  wire   badWr   = ~mapped || (selWord && testWord) || selStat;
  wire   wrWord  = access && pwrite && selWord && ~testWord;
  wire   tick    = divCnt_ff == 8'h00;

  assign prdata  = rdata_ff;
  assign pslverr = err_ff;

  wire [31:0] nxt_rdata = selWord ? {8'h00, word_ff} :
                          selCtrl ? {31'h0, ce_ff} :
                          selStat ? {30'h0, monSync_ff[1], busy} :
                          selHalf ? {24'h0, half_ff} : 32'h0;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= 32'h0;
      err_ff   <= 1'b0;
      ce_ff    <= pdsc_pkg::CE_RST;
      half_ff  <= pdsc_pkg::HALF_RST;
      monSync_ff <= 2'b11;
    end else begin
      monSync_ff <= {monSync_ff[0], link.monitorPin};
      if (psel && ~penable) begin
        rdata_ff <= pwrite ? 32'h0 : nxt_rdata;
        err_ff   <= pwrite ? badWr : ~mapped;
      end
      if (access && pwrite && selCtrl) ce_ff <= pwdata[0];
      if (access && pwrite && selHalf) half_ff <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
    end
  end

  // Serial engine: data changes with clock low, device samples on the rise
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff  <= pdsc_pkg::HS_IDLE;
      word_ff   <= 24'h000000;
      divCnt_ff <= 8'h00;
      bitCnt_ff <= 5'h00;
      sclk_ff   <= 1'b0;
      le_ff     <= 1'b0;
      phase_ff  <= 1'b0;
    end else begin
      divCnt_ff <= tick ? 8'(half_ff - 8'h01) : 8'(divCnt_ff - 8'h01);
      case (state_ff)
        pdsc_pkg::HS_IDLE: begin
          if (wrWord) begin
            word_ff   <= pwdata[23:0];
            bitCnt_ff <= 5'h00;
            phase_ff  <= 1'b0;
            divCnt_ff <= 8'(half_ff - 8'h01);
            state_ff  <= pdsc_pkg::HS_SHIFT;
          end
        end
        pdsc_pkg::HS_SHIFT: begin
          if (tick) begin
            phase_ff <= ~phase_ff;
            sclk_ff  <= ~phase_ff;
            if (phase_ff) begin
              word_ff <= {word_ff[22:0], word_ff[23]};
              if (bitCnt_ff == 5'(pdsc_pkg::WORD_W - 1)) state_ff <= pdsc_pkg::HS_LOAD;
              else bitCnt_ff <= 5'(bitCnt_ff + 5'h01);
            end
          end
        end
        pdsc_pkg::HS_LOAD: begin
          if (tick) begin
            le_ff <= ~le_ff;
            if (le_ff) state_ff <= pdsc_pkg::HS_IDLE;
          end
        end
        default: state_ff <= pdsc_pkg::HS_IDLE;
      endcase
    end
  end

  assign link.serialClk       = sclk_ff;
  assign link.serialData      = word_ff[23];
  assign link.latchLoadStrobe = le_ff;
  assign link.chipEnable      = ce_ff;
endmodule

// ===== bench/pdsc_props.sv
// Checker for the three-wire programming port between host and device
`timescale 1ns/1ns
module pdsc_props (
  input wire logic clk_sys,          // System clock
  input wire logic sys_rst,          // Asynchronous reset, active high
  input wire logic serialClk,        // Serial clock
  input wire logic serialData,       // Serial data
  input wire logic latchLoadStrobe,  // Load strobe
  input wire logic chipEnable,       // Chip enable
  input wire logic monOe,            // Monitor drive enable
  input wire logic monitorPin        // Resolved monitor pin
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  logic       sclkPrev_ff;
  logic [7:0] bitCnt_ff;
  logic [1:0] selBits_ff;
  wire        sclkRise = serialClk && !sclkPrev_ff;

  // Shadow of the last two bits shifted, as the device would see them
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sclkPrev_ff <= 1'b0;
      bitCnt_ff   <= 8'h00;
      selBits_ff  <= 2'h0;
    end else begin
      sclkPrev_ff <= serialClk;
      if (latchLoadStrobe) begin
        bitCnt_ff <= 8'h00;
      end else if (sclkRise) begin
        bitCnt_ff <= bitCnt_ff + 8'h01;
      end
      if (sclkRise) begin
        selBits_ff <= {selBits_ff[0], serialData};
      end
    end
  end

  sequence s_clkHigh;
    serialClk [*3] ##[1:300] !serialClk;
  endsequence
  sequence s_strobeHeld;
    latchLoadStrobe [*3] ##[1:300] !latchLoadStrobe;
  endsequence

  property p_data_hold;
    serialClk && $past(serialClk) |-> $stable(serialData);
  endproperty
  property p_clk_phase;
    $rose(serialClk) |-> s_clkHigh;
  endproperty
  property p_frame_len;
    $rose(latchLoadStrobe) |-> bitCnt_ff == 8'd24;
  endproperty
  property p_no_test;
    $rose(latchLoadStrobe) |-> selBits_ff != 2'b11;
  endproperty
  property p_strobe_clk_low;
    latchLoadStrobe |-> !serialClk;
  endproperty
  property p_strobe_width;
    $rose(latchLoadStrobe) |-> s_strobeHeld;
  endproperty
  property p_strobe_gap;
    $fell(latchLoadStrobe) |-> !latchLoadStrobe [*3];
  endproperty
  property p_reset_idle;
    $fell(sys_rst) |-> !chipEnable && !serialClk && !latchLoadStrobe && !monOe && monitorPin;
  endproperty

  a_data_hold: assert property (p_data_hold)
    else $error("serial data moved while clock high");
  a_clk_phase: assert property (p_clk_phase)
    else $error("serial clock high phase out of range");
  a_frame_len: assert property (p_frame_len)
    else $error("load strobe not after 24 clock rises");
  a_no_test: assert property (p_no_test)
    else $error("word sent to test latch");
  a_strobe_clk_low: assert property (p_strobe_clk_low)
    else $error("serial clock high during load strobe");
  a_strobe_width: assert property (p_strobe_width)
    else $error("load strobe width out of range");
  a_strobe_gap: assert property (p_strobe_gap)
    else $error("load strobe low phase too short");
  a_reset_idle: assert property (p_reset_idle)
    else $error("port not idle after reset");
endmodule

// ===== bench/pll_divider_serial_control_tb.sv
// Self-checking bench: host and device joined over the programming port
`timescale 1ns/1ns
module pll_divider_serial_control_tb;
  logic        clk_sys, sys_rst, psel, penable, pwrite, refIn, vcoIn, vcoRun, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, pfdRefPulse, fbPulse, lockDetect, tuneToRef;
  logic        halfRate, rfOutEnable, pumpEnable;
  logic [2:0]  bandCode;
  logic [1:0]  pulseWidth;
  logic [13:0] r;
  logic [12:0] b;
  logic [4:0]  a;
  logic [2:0]  mons [5] = '{3'h3, 3'h6, 3'h1, 3'h0, 3'h5};
  int          error_cnt, tests_run, seed, tick, refRises, vcoRises, n, k;

  pdsc_if link ();
  pdsc_host u_pdsc_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link.host));
  pdsc_device u_pdsc_device (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link.dev),
    .refIn(refIn), .vcoIn(vcoIn), .pfdRefPulse(pfdRefPulse), .fbPulse(fbPulse),
    .lockDetect(lockDetect), .tuneToRef(tuneToRef), .bandCode(bandCode),
    .pulseWidth(pulseWidth), .halfRate(halfRate), .rfOutEnable(rfOutEnable),
    .pumpEnable(pumpEnable));
  pdsc_props u_pdsc_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .serialClk(link.serialClk), .serialData(link.serialData),
    .latchLoadStrobe(link.latchLoadStrobe), .chipEnable(link.chipEnable),
    .monOe(link.monOe), .monitorPin(link.monitorPin));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Reference at clk/10, oscillator at clk/4; rises are counted here, not in the design
  always @(posedge clk_sys) begin
    tick <= tick + 1;
    if (tick % 5 == 0) begin
      refIn <= ~refIn;
      if (!refIn) refRises <= refRises + 1;
    end
    if (vcoRun && tick[0]) begin
      vcoIn <= ~vcoIn;
      if (!vcoIn) vcoRises <= vcoRises + 1;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Read just after the edge, before its updates land: these are the values it sampled
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    logic ok;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      rd = prdata;
      er = pslverr;
      ok = (pready === 1'b1);
    end while (!ok);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic send(input logic [23:0] w);
    int c;
    apb(1'b1, 8'h00, {8'h00, w});
    c = 0;
    do begin
      apb(1'b0, 8'h08, 32'h0);
      c++;
    end while (rd[0] !== 1'b0 && c < 2000);
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic measure(input logic fb);
    int c, c0;
    n = 0;
    c0 = -1;
    for (c = 0; c < 9000; c++) begin
      @(negedge clk_sys);
      if ((fb ? fbPulse : pfdRefPulse) === 1'b1) begin
        if (c0 >= 0) begin
          n = (fb ? vcoRises : refRises) - c0;
          break;
        end
        c0 = fb ? vcoRises : refRises;
      end
    end
  endtask

  task automatic waitTune(input logic want);
    for (k = 0; k < 3000 && tuneToRef !== want; k++) @(negedge clk_sys);
    // Pump control trails the band flag by one cycle
    @(negedge clk_sys);
    check("band select", 32'(tuneToRef), 32'(want));
  endtask

  function automatic logic [23:0] ctl(input logic [1:0] pre, input logic mute,
                                      input logic [2:0] mon);
    return {pre, 10'h000, mute, 3'h0, mon, 5'h00};
  endfunction

  // Far beyond the roughly 8k cycles the sequence needs
  initial begin
    #400000;
    error_cnt++;
    results();
  end

  initial begin
    seed = 32'h90459672;
    {psel, penable, pwrite, refIn, vcoIn, vcoRun} = '0;
    paddr = '0;
    pwdata = '0;
    tick = 0;
    refRises = 0;
    vcoRises = 0;
    error_cnt = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    apb(1'b0, 8'h0c, 32'h0);
    check("half default", rd, 32'h4);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped error", 32'(er), 32'h1);
    apb(1'b1, 8'h00, 32'h000003);
    check("test latch error", 32'(er), 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    check("nothing sent", 32'(rd[0]), 32'h0);
    apb(1'b1, 8'h04, 32'h1);
    for (int i = 0; i < 4; i++) begin
      r = (i == 0) ? 14'h0001 : 14'(1 + ($random(seed) & 7));
      send({4'h0, 1'b0, 1'b0, 2'(i), r, 2'b01});
      check("pulse width", 32'(pulseWidth), 32'(i));
      measure(1'b0);
      check("ref ratio", 32'(n), 32'(r));
    end
    for (int i = 0; i < 5; i++) begin
      send(ctl(2'b00, 1'b0, mons[i]));
      apb(1'b0, 8'h08, 32'h0);
      check("monitor pin", 32'(rd[1]), 32'(mons[i] == 3'h3 || mons[i] == 3'h0));
      check("monitor drive", 32'(link.monOe), 32'(mons[i] != 3'h0));
    end
    send(ctl(2'b00, 1'b1, 3'h3));
    check("muted output", 32'(rfOutEnable), 32'h0);
    send(ctl(2'b00, 1'b0, 3'h3));
    check("output on", 32'(rfOutEnable), 32'h1);
    check("pump on", 32'(pumpEnable), 32'h1);
    // No feedback during the power-up search, so every trial bit stays set
    check("band code", 32'(bandCode), 32'h7);
    apb(1'b1, 8'h0c, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    check("half floor", rd, 32'h1);
    apb(1'b1, 8'h0c, 32'h3);
    vcoRun <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      b = 13'(3 + ($random(seed) & 3));
      a = 5'(($random(seed) & 32'h7fffffff) % (b + 1));
      send(ctl(2'(p), 1'b0, 3'h3));
      send({1'b0, p[0], 1'b0, b, 1'b0, a, 2'b10});
      check("half rate", 32'(halfRate), 32'(p[0]));
      waitTune(1'b1);
      check("pump off in band", 32'(pumpEnable), 32'h0);
      waitTune(1'b0);
      check("pump back", 32'(pumpEnable), 32'h1);
      measure(1'b1);
      check("fb ratio", 32'(n), 32'(b) * (32'h8 << p) + 32'(a));
      // Feedback period always exceeds the reference period here, so no lock
      check("no lock", 32'(lockDetect), 32'h0);
    end
    apb(1'b1, 8'h04, 32'h0);
    for (k = 0; k < 50 && pumpEnable !== 1'b0; k++) @(negedge clk_sys);
    check("pump down", 32'(pumpEnable), 32'h0);
    check("output down", 32'(rfOutEnable), 32'h0);
    results();
  end
endmodule
